// [verilog/rcbp_top.sv]
// Receive cell bus port: hands stored cells to the ATM layer over a UTOPIA style bus.
// Assumes the link clock and pins come from outside pclk and the registers are on APB.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "rcbp_cfg.svh"
module rcbp_top
  import rcbp_pkg::*;
#(
  parameter int DEPTH = 128
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cell_wr_valid,
  input wire logic [15:0] cell_wr_data,
  input wire logic cell_wr_last,
  output logic cell_wr_ready,
  input wire logic rx_cell_bus_clock_in,
  input wire logic rx_read_enable_n,
  input wire logic [4:0] rx_phy_select_addr,
  output logic [15:0] rx_cell_data_bus_o,
  output logic [15:0] rx_cell_data_bus_oe,
  output logic rx_cell_odd_parity,
  output logic rx_cell_start_pulse,
  output logic rx_cell_available,
  output logic rx_cell_bus_clock_out
);

  // 800 Mbps is one 16-bit word per rising edge of a 50 MHz link clock; the
  // sampler needs at least four pclk cycles per link period to see it.
  initial
  begin
    if (`RCBP_LINK_PERIOD_CYC < `RCBP_LINK_PERIOD_MIN_CYC)
      $error("Link clock too fast for pclk edge sampling.");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Words per cell for a width and size code; zero marks an idle or
  // illegal combination, which keeps the port off the bus.
  function automatic logic [5:0] words_per_cell(input rcbp_width_t w, input rcbp_size_t s);
    logic [5:0] octets;
    octets = 6'd0;
    unique case (s)
      RCBP_S52: octets = 6'(`RCBP_OCTETS_52);
      RCBP_S53: octets = (w == RCBP_W8) ? 6'(`RCBP_OCTETS_53) : 6'd0;
      RCBP_S54: octets = 6'(`RCBP_OCTETS_54);
      RCBP_S_BAD: octets = 6'd0;
    endcase
    unique case (w)
      RCBP_W8: return octets;
      RCBP_W16: return {1'b0, octets[5:1]};
      RCBP_W_OFF: return 6'd0;
      RCBP_W_BAD: return 6'd0;
    endcase
  endfunction

  // Byte-lane merge for APB writes.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  rcbp_state_t q;
  rcbp_state_t d;
  rcbp_fifo_if f ();
  logic pop_c;
  logic pop_first_c;
  logic link_rise;
  rcbp_width_t width;
  rcbp_size_t size;
  logic [5:0] words;
  logic multi;
  logic level12;
  logic en_eff_n;
  logic [4:0] addr_now;
  logic selected;
  logic last;
  logic [15:0] word;

  assign width = rcbp_width_t'(q.ctrl[`RCBP_WIDTH_LO +: 2]);
  assign size = rcbp_size_t'(q.ctrl[`RCBP_SIZE_LO +: 2]);
  assign words = words_per_cell(width, size);
  assign multi = q.ctrl[`RCBP_MPHY_BIT];
  assign level12 = q.ctrl[`RCBP_LEVEL_BIT];
  assign link_rise = q.lclk_s[1] && !q.lclk_s[2];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // APB answers in one access cycle; read data is captured in the setup
  // cycle so that it comes straight from a flip-flop.
  always_comb
  begin
    d = q;
    pop_c = 1'b0;
    pop_first_c = 1'b0;
    last = 1'b0;
    word = 16'h0000;
    d.pready = psel && !penable;
    if (psel && !penable)
    begin
      d.pslverr = 1'b0;
      d.prdata = 32'h0000_0000;
      if (paddr == `RCBP_CTRL_ADDR)
        d.prdata = q.ctrl;
      else if (paddr == `RCBP_STAT_ADDR)
        d.prdata = {16'h0000, 3'b000, q.addr_lat, 5'b00000, q.mid, q.soc, q.clav};
      else
        d.pslverr = 1'b1;
    end
    if (psel && penable && q.pready && pwrite && paddr == `RCBP_CTRL_ADDR)
      d.ctrl = merge_bytes(q.ctrl, pwdata, pstrb) & `RCBP_CTRL_MASK;

    // Enable and address pass two flip-flops and the link clock three; the second stage is read, and edges also compare the clock's third.
    d.lclk_s = {q.lclk_s[1:0], rx_cell_bus_clock_in};
    d.en_s_n = {q.en_s_n[0], rx_read_enable_n};
    d.addr_s1 = rx_phy_select_addr;
    d.addr_s2 = q.addr_s1;

    // Level 3 acts on read enable one link period later than Levels 1/2.
    en_eff_n = level12 ? q.en_s_n[1] : q.en_prev_n;
    // Selection uses the address latched at the last link edge, not the live pins.
    addr_now = q.addr_lat;
    selected = !multi || addr_now == q.ctrl[`RCBP_PHY_LO +: 5];

    // The de-skew output follows the sampled link clock when enabled.
    d.clkout = q.ctrl[`RCBP_PLL_BIT] && q.lclk_s[1];

    // Cell available covers only unstarted complete cells of this PHY.
    d.clav = (words != 6'd0) && f.cells_avail && selected;

    if (words == 6'd0)
    begin
      d.ptr = 6'd0;
      d.mid = 1'b0;
    end

    // A switch away from sixteen-bit mode must not leave the upper lanes driven.
    if (width != RCBP_W16)
      d.oe[15:8] = 8'h00;

    // Data, parity, start of cell and lane enables move on a detected link clock rising edge; only the upper-lane clear above acts at once.
    if (link_rise)
    begin
      d.en_prev_n = q.en_s_n[1];
      if (multi)
        d.addr_lat = q.addr_s2;
      if (words == 6'd0 || en_eff_n || !selected)
      begin
        d.oe = 16'h0000;
        d.soc = 1'b0;
      end
      else
      begin
        d.oe = (width == RCBP_W16) ? 16'hFFFF : 16'h00FF;
        d.soc = 1'b0;
        if (q.mid || f.cells_avail)
        begin
          word = (width == RCBP_W16) ? f.rd_data : {8'h00, f.rd_data[7:0]};
          last = q.ptr >= words - 6'd1;
          d.data = word;
          d.par = ~^word;
          d.soc = q.ptr == 6'd0;
          pop_c = 1'b1;
          pop_first_c = !q.mid;
          d.ptr = last ? 6'd0 : q.ptr + 6'd1;
          d.mid = !last;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Clock enable low freezes everything, including the pin samplers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.ctrl <= `RCBP_CTRL_RESET;
      q.lclk_s <= 3'b000;
      q.en_s_n <= 2'b11;
      q.en_prev_n <= 1'b1;
    end
    else if (ce)
      q <= d;
  end

  assign f.pop = pop_c && ce;
  assign f.pop_first = pop_first_c && ce;

  // ----------------------------------------------------------------
  // Cell store
  // ----------------------------------------------------------------

  rcbp_cell_store #(
    .DEPTH(DEPTH)
  ) u_store (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .wr_valid(cell_wr_valid),
    .wr_data(cell_wr_data),
    .wr_last(cell_wr_last),
    .wr_ready(cell_wr_ready),
    .f(f.store)
  );

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign rx_cell_data_bus_o = q.data;
  assign rx_cell_data_bus_oe = q.oe;
  assign rx_cell_odd_parity = q.par;
  assign rx_cell_start_pulse = q.soc;
  assign rx_cell_available = q.clav;
  assign rx_cell_bus_clock_out = q.clkout;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  a_hiz_when_high: assert property (@(posedge pclk) disable iff (!presetn)
    ce && link_rise && level12 && q.en_s_n[1] |=> q.oe == 16'h0000)
    else $error("Data bus driven while read enable high.");
  a_data_on_edge: assert property (@(posedge pclk) disable iff (!presetn)
    q.data != $past(q.data) |-> $past(link_rise))
    else $error("Data bus changed away from a link clock edge.");
  a_upper_lanes_off: assert property (@(posedge pclk) disable iff (!presetn)
    width != RCBP_W16 && $past(width) != RCBP_W16 |-> q.oe[15:8] == 8'h00)
    else $error("Upper data lanes driven outside sixteen-bit mode.");
  a_addr_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    !multi && $past(!multi) |-> $stable(q.addr_lat))
    else $error("PHY address latched outside multi-PHY mode.");
  a_addr_latched: assert property (@(posedge pclk) disable iff (!presetn)
    ce && link_rise && multi |=> q.addr_lat == $past(q.addr_s2))
    else $error("PHY address not latched at link edge.");
  a_parity_odd: assert property (@(posedge pclk) disable iff (!presetn)
    ce && pop_c |=> ^{q.par, q.data} == 1'b1)
    else $error("Parity is not odd over the driven word.");
  a_soc_first_word: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(q.soc) |-> $past(link_rise) && q.oe[0] && $past(q.ptr) == 6'd0)
    else $error("Start of cell raised away from the first word.");
  a_soc_one_period: assert property (@(posedge pclk) disable iff (!presetn)
    ce && link_rise && q.soc && d.ptr != 6'd0 |=> !q.soc)
    else $error("Start of cell held past one link period.");
  a_ptr_holds: assert property (@(posedge pclk) disable iff (!presetn)
    ce && en_eff_n && words != 6'd0 |=> q.ptr == $past(q.ptr))
    else $error("Word pointer moved while read enable high.");
  a_clock_out_off: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !q.ctrl[`RCBP_PLL_BIT] |=> !q.clkout)
    else $error("Clock output running with de-skew disabled.");
  a_clav_tracks: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !f.cells_avail |=> !q.clav)
    else $error("Cell available high with no complete cell stored.");
endmodule

// [inc/rcbp_cfg.svh]
// Offsets, field positions, reset values and timing figures of the receive cell bus port.
// Assumes a 12-bit APB byte address and 32-bit register words.
`ifndef RCBP_CFG_SVH
`define RCBP_CFG_SVH

// Register byte addresses.
`define RCBP_CTRL_ADDR 12'h000
`define RCBP_STAT_ADDR 12'h004

// Control register field positions.
`define RCBP_SIZE_LO 0
`define RCBP_WIDTH_LO 2
`define RCBP_MPHY_BIT 6
`define RCBP_LEVEL_BIT 7
`define RCBP_PLL_BIT 8
`define RCBP_PHY_LO 16
`define RCBP_CTRL_MASK 32'h001F_01FF
`define RCBP_CTRL_RESET 32'h0000_0083

// Octets per cell for each cell size code.
`define RCBP_OCTETS_52 52
`define RCBP_OCTETS_53 53
`define RCBP_OCTETS_54 54

// Clock figures in MHz and the cycle counts derived from them.
`define RCBP_PCLK_MHZ 250
`define RCBP_LINK_MHZ_LOW 25
`define RCBP_LINK_MHZ_MID 33
`define RCBP_LINK_MHZ_MAX 50
`define RCBP_LINK_PERIOD_CYC (`RCBP_PCLK_MHZ / `RCBP_LINK_MHZ_MAX)
`define RCBP_LINK_PERIOD_MIN_CYC 4

`endif

// [inc/rcbp_pkg.sv]
// Types shared by the receive cell bus port modules.
// Assumes rcbp_cfg.svh is included by each user for the constants.
package rcbp_pkg;

  typedef enum logic [1:0] {
    RCBP_W_OFF,
    RCBP_W8,
    RCBP_W16,
    RCBP_W_BAD
  } rcbp_width_t;

  typedef enum logic [1:0] {
    RCBP_S52,
    RCBP_S53,
    RCBP_S54,
    RCBP_S_BAD
  } rcbp_size_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] lclk_s;
    logic [1:0] en_s_n;
    logic en_prev_n;
    logic [4:0] addr_s1;
    logic [4:0] addr_s2;
    logic [4:0] addr_lat;
    logic [15:0] data;
    logic [15:0] oe;
    logic par;
    logic soc;
    logic clav;
    logic clkout;
    logic [5:0] ptr;
    logic mid;
  } rcbp_state_t;

endpackage

// [inc/rcbp_fifo_if.sv]
// Read side of the receive cell store, between the port logic and the store.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface rcbp_fifo_if;
  logic [15:0] rd_data;
  logic cells_avail;
  logic pop;
  logic pop_first;
  modport port (input rd_data, input cells_avail, output pop, output pop_first);
  modport store (output rd_data, output cells_avail, input pop, input pop_first);
endinterface

// [verilog/rcbp_cell_store.sv]
// Receive cell store: word memory fed by the cell processor, drained by the port.
// Assumes the writer marks the last word of each cell and writes whole cells only.
`timescale 1ns/1ps
`include "rcbp_cfg.svh"
module rcbp_cell_store
  import rcbp_pkg::*;
#(
  parameter int DEPTH = 128
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic wr_valid,
  input wire logic [15:0] wr_data,
  input wire logic wr_last,
  output logic wr_ready,
  rcbp_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 64 || (DEPTH & (DEPTH - 1)) != 0)
      $error("Cell store depth must be a power of two of at least 64 words.");
  end

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] cells;
    logic ready;
  } rcbp_store_t;

  rcbp_store_t q;
  rcbp_store_t d;
  logic [15:0] mem [DEPTH];
  logic push;

  // ----------------------------------------------------------------
  // Pointer and cell bookkeeping
  // ----------------------------------------------------------------

  // A cell counts as available only until its first word leaves, so the
  // port never offers a partly drained cell as a complete one.
  always_comb
  begin
    d = q;
    push = wr_valid && q.ready;
    if (push)
      d.wr_ptr = q.wr_ptr + 1'b1;
    if (f.pop)
      d.rd_ptr = q.rd_ptr + 1'b1;
    d.count = q.count + (AW + 1)'(push) - (AW + 1)'(f.pop);
    d.cells = q.cells + (AW + 1)'(push && wr_last) - (AW + 1)'(f.pop_first);
    d.ready = d.count < (AW + 1)'(DEPTH);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else if (ce)
      q <= d;
  end

  // Memory has no reset; only written words are ever read.
  always_ff @(posedge pclk)
  begin
    if (ce && push)
      mem[q.wr_ptr] <= wr_data;
  end

  assign wr_ready = q.ready;
  assign f.rd_data = mem[q.rd_ptr];
  assign f.cells_avail = q.cells != '0;

  a_no_overflow: assert property (@(posedge pclk) disable iff (!presetn)
    q.count <= (AW + 1)'(DEPTH))
    else $error("Cell store holds more words than its depth.");
  a_cell_count: assert property (@(posedge pclk) disable iff (!presetn)
    ce && push && wr_last && !f.pop_first |=> q.cells == $past(q.cells) + 1'b1)
    else $error("Completed cell not counted.");
endmodule

// [bench/rcbp_atm_model.sv]
// ATM layer reader model: makes the link clock, read enable and PHY address.
// Assumes the port settles its outputs within half a link period of each edge.
`timescale 1ns/1ps
module rcbp_atm_model
(
  input wire logic [15:0] data_o,
  input wire logic [15:0] data_oe,
  input wire logic par,
  input wire logic soc,
  output logic lclk,
  output logic en_n,
  output logic [4:0] addr
);
  logic [33:0] cap[$];
  logic [15:0] bus;
  logic [15:0] last_q;

  // Released lines show the inverse of their last level, so stale data never matches.
  assign bus = (data_o & data_oe) | (~last_q & ~data_oe);

  // Track the wire level seen at each link edge.
  always @(posedge lclk)
    last_q <= bus;

  // The clock stands low until a transfer or an address sample is wanted.
  initial
  begin
    lclk = 1'b0;
    en_n = 1'b1;
    addr = 5'h00;
    last_q = 16'h0000;
  end

  // One 64 ns link period; enable moves mid-low so it never races the rising edge.
  task automatic cycle(input logic en, input logic keep);
    #16 en_n = en;
    #16;
    if (keep)
      cap.push_back({soc, par, data_oe, bus});
    lclk = 1'b1;
    #32 lclk = 1'b0;
  endtask

  // Reads n words; lat extra edges pass before the first word in Level 3.
  task automatic read(input int n, input int lat);
    for (int i = 0; i <= n + lat; i++)
      cycle(i >= n, i > lat);
  endtask
endmodule

// [bench/tb_rx_cell_bus_output_port.sv]
// Self-checking bench for the receive cell bus port, with an ATM layer reader model.
// Assumes one APB access cycle per transfer and whole cells written to the store.
`timescale 1ns/1ps
`include "rcbp_cfg.svh"
module tb_rx_cell_bus_output_port;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cell_wr_valid;
  logic [15:0] cell_wr_data;
  logic cell_wr_last;
  logic cell_wr_ready;
  logic lclk;
  logic en_n;
  logic [4:0] addr;
  logic [15:0] d_o;
  logic [15:0] d_oe;
  logic par;
  logic soc;
  logic clav;
  logic clk_out;
  int err_count = 0;
  int compares = 0;
  int n_clkout = 0;

  rcbp_top #(.DEPTH(128)) i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cell_wr_valid(cell_wr_valid),
    .cell_wr_data(cell_wr_data), .cell_wr_last(cell_wr_last), .cell_wr_ready(cell_wr_ready),
    .rx_cell_bus_clock_in(lclk), .rx_read_enable_n(en_n), .rx_phy_select_addr(addr),
    .rx_cell_data_bus_o(d_o), .rx_cell_data_bus_oe(d_oe), .rx_cell_odd_parity(par),
    .rx_cell_start_pulse(soc), .rx_cell_available(clav), .rx_cell_bus_clock_out(clk_out));

  rcbp_atm_model m (.data_o(d_o), .data_oe(d_oe), .par(par), .soc(soc), .lclk(lclk),
    .en_n(en_n), .addr(addr));

  // 250 MHz system clock.
  always #2 pclk = ~pclk;

  // Counts clock output edges to see whether the de-skew output runs.
  always @(posedge clk_out)
    n_clkout++;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits at falling edges, so the value seen is the one the next rising edge samples.
  task automatic wait_hi(input int sel);
    int n;
    n = 0;
    @(negedge pclk);
    while ((sel ? cell_wr_ready : pready) !== 1'b1 && n < 100)
    begin
      @(negedge pclk);
      n++;
    end
    if (n == 100)
    begin
      err_count++;
      close_out();
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    wait_hi(0);
    @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic xerr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk(48'({rd, err}), 48'({exp, xerr}));
  endtask

  task automatic wreg(input logic [11:0] a, input logic [31:0] d, input logic xerr);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
    chk(48'(err), 48'(xerr));
  endtask

  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask

  task automatic put_cell(input int n, input logic [15:0] seed);
    @(posedge pclk);
    for (int i = 0; i < n; i++)
    begin
      cell_wr_valid <= 1'b1;
      cell_wr_data <= seed + 16'(i);
      cell_wr_last <= (i == n - 1);
      wait_hi(1);
      @(posedge pclk);
    end
    cell_wr_valid <= 1'b0;
  endtask

  // Compares every captured word with its pattern, parity, enable mask and start flag.
  task automatic check_cell(input int n, input logic [15:0] seed, input logic [15:0] mask);
    logic [33:0] e;
    logic [15:0] w;
    for (int i = 0; i < n; i++)
    begin
      e = m.cap[i];
      w = (seed + 16'(i)) & mask;
      chk(48'({e[33:16], e[15:0] & mask}), 48'({i == 0, ~^w, mask, w}));
    end
    m.cap.delete();
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    chk(48'({clav, d_oe}), 48'(0));
    rchk(`RCBP_CTRL_ADDR, 32'h0000_0083, 1'b0);
    rchk(`RCBP_STAT_ADDR, 32'h0000_0000, 1'b0);
    rchk(12'h008, 32'h0000_0000, 1'b1);
    wreg(12'h00C, 32'hFFFF_FFFF, 1'b1);
    wreg(`RCBP_CTRL_ADDR, 32'hFFFF_FFFF, 1'b0);
    rchk(`RCBP_CTRL_ADDR, 32'h001F_01FF, 1'b0);
    wreg(`RCBP_STAT_ADDR, 32'hFFFF_FFFF, 1'b0);
    rchk(`RCBP_STAT_ADDR, 32'h0000_0000, 1'b0);
  endtask

  // Two byte-wide 52-octet cells; the first is paused mid-cell.
  task automatic t_byte_cells();
    wreg(`RCBP_CTRL_ADDR, 32'h0000_0084, 1'b0);
    put_cell(52, 16'h12A7);
    put_cell(52, 16'h3C5A);
    settle();
    rchk(`RCBP_STAT_ADDR, 32'h0000_0001, 1'b0);
    m.read(20, 0);
    repeat (3) m.cycle(1'b1, 1'b0);
    chk(48'(d_oe), 48'(0));
    m.read(32, 0);
    check_cell(52, 16'h12A7, 16'h00FF);
    chk(48'(clav), 48'(1));
    m.read(52, 0);
    check_cell(52, 16'h3C5A, 16'h00FF);
    settle();
    chk(48'(clav), 48'(0));
  endtask

  // Invalid settings keep the port off; then a 54-octet word-wide cell in Level 3.
  task automatic t_word_level3();
    logic [31:0] bad[4] = '{32'h0000_000E, 32'h0000_0009, 32'h0000_000B, 32'h0000_0002};
    int n0;
    put_cell(27, 16'hF0E1);
    for (int i = 0; i < 4; i++)
    begin
      wreg(`RCBP_CTRL_ADDR, bad[i], 1'b0);
      settle();
      chk(48'(clav), 48'(0));
    end
    wreg(`RCBP_CTRL_ADDR, 32'h0000_000A, 1'b0);
    settle();
    chk(48'(clav), 48'(1));
    n0 = n_clkout;
    m.read(27, 1);
    check_cell(27, 16'hF0E1, 16'hFFFF);
    chk(48'(n_clkout - n0), 48'(0));
  endtask

  // Address ignored in single-PHY mode, then gating by the latched address.
  task automatic t_multi_phy();
    int n0;
    put_cell(27, 16'h0F1E);
    m.addr = 5'h03;
    wreg(`RCBP_CTRL_ADDR, 32'h0000_010A, 1'b0);
    n0 = n_clkout;
    repeat (4) m.cycle(1'b1, 1'b0);
    chk(48'(n_clkout - n0), 48'(4));
    chk(48'(clav), 48'(1));
    wreg(`RCBP_CTRL_ADDR, 32'h0005_014A, 1'b0);
    repeat (4) m.cycle(1'b1, 1'b0);
    settle();
    rchk(`RCBP_STAT_ADDR, 32'h0000_0300, 1'b0);
    m.addr = 5'h05;
    repeat (4) m.cycle(1'b1, 1'b0);
    settle();
    chk(48'(clav), 48'(1));
    m.read(27, 1);
    check_cell(27, 16'h0F1E, 16'hFFFF);
  endtask

  // Cuts a hang short.
  initial
  begin
    #200000;
    err_count++;
    close_out();
  end

  // Main sequence: reset for ten cycles, then the scenarios in turn.
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    cell_wr_valid = 1'b0;
    cell_wr_data = 16'h0000;
    cell_wr_last = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_byte_cells();
    t_word_level3();
    t_multi_phy();
    close_out();
  end
endmodule
